// ==== hdl/packer_pkg.sv ====
// Package with register map, field layout, reset values and state type of the field packer.
package packer_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_FIELD_LEN = 8'h08;
    localparam logic [7:0] OFS_VAR_LEN = 8'h0C;
    localparam logic [7:0] OFS_BASE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RX_COUNT = 8'h18;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
    localparam logic [7:0] OFS_MEM_DATA = 8'h20;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_VAR_BIT = 0;
    localparam int CTRL_LOW_BIT = 1;
    localparam int CTRL_SWAP_BIT = 2;
    localparam int CMD_TX_BIT = 0;
    localparam int CMD_RX_BIT = 1;
    localparam int ST_TX_BUSY_BIT = 0;
    localparam int ST_RX_BUSY_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_OVF_BIT = 3;
    // ****************************************
    // Lengths and reset values
    // ****************************************
    localparam int LEN_W = 12;
    localparam logic [11:0] MIN_LEN = 12'h001;
    localparam logic [11:0] MAX_LEN = 12'h800;
    localparam logic [11:0] FIELD_LEN_RST = 12'h001;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} state_t;
endpackage

// ==== hdl/packet_variable_field_packer.sv ====
// Packer and unpacker of a non-converted variable field between word storage and a byte stream.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module packet_variable_field_packer #(
    parameter int MEM_WORDS = 2048,
    parameter int MEM_AW = $clog2(MEM_WORDS)
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [7:0] o_tx_data,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_valid,
    input wire logic i_rx_last,
    output logic o_rx_ready
);
    logic var_mode, low_only, swap_en, done, ovf;
    logic [11:0] field_len, var_len, rx_count, pos, len, tx_len, q_tx, q_rx;
    logic [MEM_AW-1:0] base, mem_addr, w_tx;
    logic [15:0] mem [MEM_WORDS];
    logic [7:0] pend, tx_byte;
    packer_pkg::state_t state;
    logic [7:0] buf_data [packer_pkg::BUF_DEPTH];
    logic wr_ptr, rd_ptr, buf_ready, push, pop, rx_fire, rx_last, tx_last;
    logic [1:0] buf_cnt;
    logic wr_en [2];
    logic [11:0] wr_idx [2];
    logic [7:0] wr_byte [2];
    logic [MEM_AW-1:0] wr_word [2];
    logic sel_ctrl, sel_cmd, sel_flen, sel_vlen, sel_base, sel_stat, sel_maddr, sel_mdata;

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [11:0] clamp_len(input logic [31:0] v, input logic [11:0] hi);
        if (v < {20'h0, packer_pkg::MIN_LEN}) begin
            return packer_pkg::MIN_LEN;
        end
        if (v > {20'h0, hi}) begin
            return hi;
        end
        return v[11:0];
    endfunction

    // Stream position to storage byte position; an odd final byte may be kept in place.
    function automatic logic [11:0] src_idx(input logic [11:0] p, input logic [11:0] n, input logic keep);
        if (swap_en && !(keep && n[0] && (p == n - 12'h001))) begin
            return p ^ 12'h001;
        end
        return p;
    endfunction

    function automatic logic [MEM_AW-1:0] word_of(input logic [11:0] q);
        return base + MEM_AW'(low_only ? q : (q >> 1));
    endfunction

    // ****************************************
    // Register port
    // ****************************************
    assign sel_ctrl = i_addr == packer_pkg::OFS_CTRL;
    assign sel_cmd = i_addr == packer_pkg::OFS_CMD;
    assign sel_flen = i_addr == packer_pkg::OFS_FIELD_LEN;
    assign sel_vlen = i_addr == packer_pkg::OFS_VAR_LEN;
    assign sel_base = i_addr == packer_pkg::OFS_BASE;
    assign sel_stat = i_addr == packer_pkg::OFS_STATUS;
    assign sel_maddr = i_addr == packer_pkg::OFS_MEM_ADDR;
    assign sel_mdata = i_addr == packer_pkg::OFS_MEM_DATA;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {swap_en, low_only, var_mode} <= packer_pkg::CTRL_RST;
            field_len <= packer_pkg::FIELD_LEN_RST;
            var_len <= packer_pkg::FIELD_LEN_RST;
            base <= '0;
        end else if (i_wr) begin
            if (sel_ctrl) begin
                var_mode <= i_wdata[packer_pkg::CTRL_VAR_BIT];
                low_only <= i_wdata[packer_pkg::CTRL_LOW_BIT];
                swap_en <= i_wdata[packer_pkg::CTRL_SWAP_BIT];
            end
            if (sel_flen) begin
                field_len <= clamp_len(i_wdata, packer_pkg::MAX_LEN);
            end
            if (sel_vlen) begin
                var_len <= clamp_len(i_wdata, field_len);
            end
            if (sel_base) begin
                base <= i_wdata[MEM_AW-1:0];
            end
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= 32'h00000000;
            unique case (1'b1)
                sel_ctrl: o_rdata[2:0] <= {swap_en, low_only, var_mode};
                sel_flen: o_rdata[11:0] <= field_len;
                sel_vlen: o_rdata[11:0] <= var_len;
                sel_base: o_rdata[MEM_AW-1:0] <= base;
                sel_stat: o_rdata[3:0] <= {ovf, done, state == packer_pkg::ST_RX, state == packer_pkg::ST_TX};
                sel_rx_cnt(): o_rdata[11:0] <= rx_count;
                sel_maddr: o_rdata[MEM_AW-1:0] <= mem_addr;
                sel_mdata: o_rdata[15:0] <= mem[mem_addr];
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    function automatic logic sel_rx_cnt();
        return i_addr == packer_pkg::OFS_RX_COUNT;
    endfunction

    // Window pointer steps after each data access so software can stream words.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mem_addr <= '0;
        end else if (i_wr && sel_maddr) begin
            mem_addr <= i_wdata[MEM_AW-1:0];
        end else if ((i_wr || i_rd) && sel_mdata) begin
            mem_addr <= mem_addr + MEM_AW'(1);
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    assign tx_len = var_mode ? ((var_len > field_len) ? field_len : var_len) : field_len;
    assign o_rx_ready = state == packer_pkg::ST_RX;
    assign rx_fire = o_rx_ready && i_rx_valid;
    assign rx_last = (pos == len - 12'h001) || (var_mode && i_rx_last);
    assign push = (state == packer_pkg::ST_TX) && buf_ready;
    assign tx_last = pos == len - 12'h001;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= packer_pkg::ST_IDLE;
            pos <= 12'h000;
            len <= packer_pkg::FIELD_LEN_RST;
        end else begin
            unique case (state)
                packer_pkg::ST_IDLE: begin
                    pos <= 12'h000;
                    if (i_wr && sel_cmd && i_wdata[packer_pkg::CMD_TX_BIT]) begin
                        state <= packer_pkg::ST_TX;
                        len <= tx_len;
                    end else if (i_wr && sel_cmd && i_wdata[packer_pkg::CMD_RX_BIT]) begin
                        state <= packer_pkg::ST_RX;
                        len <= field_len;
                    end
                end
                packer_pkg::ST_TX: begin
                    if (push) begin
                        pos <= pos + 12'h001;
                        if (tx_last) begin
                            state <= packer_pkg::ST_IDLE;
                        end
                    end
                end
                packer_pkg::ST_RX: begin
                    if (rx_fire) begin
                        pos <= pos + 12'h001;
                        if (rx_last) begin
                            state <= packer_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= packer_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Flags set by the sequencer win over a clear in the same cycle.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done <= 1'b0;
            ovf <= 1'b0;
            rx_count <= 12'h000;
        end else begin
            if ((push && tx_last) || (rx_fire && rx_last)) begin
                done <= 1'b1;
            end else if (i_wr && sel_stat && i_wdata[packer_pkg::ST_DONE_BIT]) begin
                done <= 1'b0;
            end
            if (rx_fire && var_mode && !i_rx_last && (pos == len - 12'h001)) begin
                ovf <= 1'b1;
            end else if (i_wr && sel_stat && i_wdata[packer_pkg::ST_OVF_BIT]) begin
                ovf <= 1'b0;
            end
            if (rx_fire && rx_last) begin
                rx_count <= pos + 12'h001;
            end
        end
    end

    // ****************************************
    // Transmit byte selection and buffer
    // ****************************************
    assign q_tx = src_idx(pos, len, low_only);
    assign w_tx = word_of(q_tx);
    assign tx_byte = (!low_only && q_tx[0]) ? mem[w_tx][15:8] : mem[w_tx][7:0];

    // Two entries let the sender keep one byte ahead while the receiver stalls.
    assign buf_ready = buf_cnt != 2'(packer_pkg::BUF_DEPTH);
    assign o_tx_valid = buf_cnt != 2'h0;
    assign o_tx_data = buf_data[rd_ptr];
    assign pop = o_tx_valid && i_tx_ready;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            buf_cnt <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_data[0] <= 8'h00;
            buf_data[1] <= 8'h00;
        end else begin
            if (push) begin
                buf_data[wr_ptr] <= tx_byte;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
        end
    end

    // ****************************************
    // Receive byte placement and storage
    // ****************************************
    assign q_rx = src_idx(pos, len, 1'b1);

    // With swap the even byte waits; the pair is written together, an unpaired last byte goes in place.
    always_comb begin
        wr_en[0] = 1'b0;
        wr_en[1] = 1'b0;
        wr_idx[0] = pos;
        wr_idx[1] = pos - 12'h001;
        wr_byte[0] = i_rx_data;
        wr_byte[1] = pend;
        if (rx_fire) begin
            if (!swap_en || (rx_last && !pos[0])) begin
                wr_en[0] = 1'b1;
            end else if (pos[0]) begin
                wr_en[0] = 1'b1;
                wr_en[1] = 1'b1;
                wr_idx[0] = q_rx;
                wr_idx[1] = pos;
            end
        end
        wr_word[0] = word_of(wr_idx[0]);
        wr_word[1] = word_of(wr_idx[1]);
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend <= 8'h00;
        end else if (rx_fire && !pos[0]) begin
            pend <= i_rx_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (wr_en[k]) begin
                if (low_only) begin
                    mem[wr_word[k]] <= {8'h00, wr_byte[k]};
                end else if (wr_idx[k][0]) begin
                    mem[wr_word[k]][15:8] <= wr_byte[k];
                end else begin
                    mem[wr_word[k]][7:0] <= wr_byte[k];
                end
            end
        end
        if (i_wr && sel_mdata) begin
            mem[mem_addr] <= i_wdata[15:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_len_range;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        field_len >= packer_pkg::MIN_LEN && field_len <= packer_pkg::MAX_LEN;
    endproperty
    a_len_range: assert property (p_len_range) else $error("field length out of range");

    property p_var_bound;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(state == packer_pkg::ST_TX) |-> len <= field_len && (!var_mode || len <= var_len);
    endproperty
    a_var_bound: assert property (p_var_bound) else $error("send length exceeds bound");

    property p_tx_end;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        push && tx_last |=> state == packer_pkg::ST_IDLE && done && pos == len;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("send did not end after last byte");

    property p_rx_var;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        rx_fire && var_mode && i_rx_last |=> state == packer_pkg::ST_IDLE && rx_count == $past(pos) + 12'h001;
    endproperty
    a_rx_var: assert property (p_rx_var) else $error("variable receive count wrong");

    property p_tx_var_len;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_wr && sel_cmd && i_wdata[0] && state == packer_pkg::ST_IDLE && var_mode && var_len <= field_len
        |=> len == $past(var_len);
    endproperty
    a_tx_var_len: assert property (p_tx_var_len) else $error("send length not taken from software");

    property p_tx_order;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        push && !low_only && !swap_en |->
        tx_byte == (pos[0] ? mem[base + MEM_AW'(pos >> 1)][15:8] : mem[base + MEM_AW'(pos >> 1)][7:0]);
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("word bytes sent in wrong order");

    property p_tx_swap;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        push && !low_only && swap_en |->
        tx_byte == (pos[0] ? mem[base + MEM_AW'(pos >> 1)][7:0] : mem[base + MEM_AW'(pos >> 1)][15:8]);
    endproperty
    a_tx_swap: assert property (p_tx_swap) else $error("swapped send byte wrong");

    property p_rx_low;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        rx_fire && low_only && !swap_en |=> mem[$past(base + MEM_AW'(pos))] == {8'h00, $past(i_rx_data)};
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("lower-byte store wrong");

    property p_rx_pair;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        rx_fire && !low_only && !swap_en && pos[0] |=>
        mem[$past(base + MEM_AW'(pos >> 1))][15:8] == $past(i_rx_data);
    endproperty
    a_rx_pair: assert property (p_rx_pair) else $error("second byte not in upper half");

    c_tx_done: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) push && tx_last);
    c_rx_var: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) rx_fire && var_mode && i_rx_last);
    c_rx_swap: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) wr_en[1]);
    c_stall: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) (o_tx_valid && !i_tx_ready)[*2]);
endmodule

// ==== testbench/serial_device_model.sv ====
// Behavioural model of the external serial device on the far side of the field packer.
`timescale 1ns/100ps
module serial_device_model (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_slow,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready = 1'b0,
    output logic [7:0] o_rx_data = 8'h00,
    output logic o_rx_valid = 1'b0,
    output logic o_rx_last = 1'b0,
    input wire logic i_rx_ready
);
    // ****************************************
    // Byte queues and line behaviour
    // ****************************************
    logic [8:0] rx_q [$];
    logic [7:0] got_q [$];
    // A slow device stalls at random so that the two-entry buffer really fills.
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tx_ready <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_last <= 1'b0;
        end else begin
            if (i_tx_valid && o_tx_ready) begin
                got_q.push_back(i_tx_data);
            end
            o_tx_ready <= !i_slow || $urandom_range(1, 0) == 1;
            if (o_rx_valid && !i_rx_ready) begin
                o_rx_valid <= 1'b1;
            end else if (rx_q.size() > 0 && (!i_slow || $urandom_range(1, 0) == 1)) begin
                {o_rx_last, o_rx_data} <= rx_q.pop_front();
                o_rx_valid <= 1'b1;
            end else begin
                // An idle line shows a changing pattern, never a held byte.
                o_rx_data <= ~o_rx_data;
                o_rx_valid <= 1'b0;
                o_rx_last <= 1'b0;
            end
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking testbench of the variable field packer.
`timescale 1ns/100ps
module tb_top;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic slow = 1'b0;
    logic [31:0] o_rdata;
    logic [7:0] o_tx_data;
    logic [7:0] i_rx_data;
    logic o_tx_valid, i_tx_ready, i_rx_valid, i_rx_last, o_rx_ready;
    logic [15:0] mem [64];
    logic [15:0] msk [64];
    int bad_count = 0;
    int compares = 0;
    packet_variable_field_packer #(.MEM_WORDS(64)) i_packet_variable_field_packer (.i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .i_rx_data(i_rx_data),
        .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready));
    serial_device_model i_serial_device_model (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_slow(slow),
        .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready), .o_rx_data(i_rx_data),
        .o_rx_valid(i_rx_valid), .o_rx_last(i_rx_last), .i_rx_ready(o_rx_ready));
    // ****************************************
    // Bus tasks and expectations
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        check(d, exp, what);
    endtask
    task automatic fill_mem(input logic v, input logic l, input logic s, input int flen, input int n, input int base);
        wr(packer_pkg::OFS_MEM_ADDR, 32'h0);
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'($urandom);
            msk[i] = 16'hFFFF;
            wr(packer_pkg::OFS_MEM_DATA, {16'h0000, mem[i]});
        end
        wr(packer_pkg::OFS_CTRL, {29'h0, s, l, v});
        wr(packer_pkg::OFS_FIELD_LEN, 32'(flen));
        wr(packer_pkg::OFS_VAR_LEN, 32'(n));
        wr(packer_pkg::OFS_BASE, 32'(base));
        slow <= 1'($urandom_range(1, 0));
    endtask
    // Storage position of stream byte p.
    function automatic int src_idx(input int p, input int n, input logic l, input logic s, input logic tx);
        if (!s || ((n % 2) == 1 && p == n - 1 && (l || !tx))) return p;
        return p ^ 1;
    endfunction
    function automatic logic [7:0] tx_byte(input int p, input int n, input int base, input logic l, input logic s);
        int q;
        logic [15:0] w;
        q = src_idx(p, n, l, s, 1'b1);
        w = mem[(base + (l ? q : q / 2)) % 64];
        return (!l && q % 2 == 1) ? w[15:8] : w[7:0];
    endfunction
    task automatic run_tx(input logic v, input logic l, input logic s, input int n, input int flen, input int base);
        fill_mem(v, l, s, flen, n, base);
        wr(packer_pkg::OFS_CMD, 32'h1);
        for (int k = 0; k < 400 && i_serial_device_model.got_q.size() < n; k++) @(posedge i_ref_clk);
        repeat (8) @(posedge i_ref_clk);
        check(32'(i_serial_device_model.got_q.size()), 32'(n), "send byte count");
        for (int p = 0; p < n; p++) begin
            check({24'h0, i_serial_device_model.got_q[p]}, {24'h0, tx_byte(p, n, base, l, s)}, "send byte");
        end
        i_serial_device_model.got_q.delete();
        rchk(packer_pkg::OFS_STATUS, 32'h4, "send status");
        wr(packer_pkg::OFS_STATUS, 32'hF);
        $display("send test done: len %0d ctrl %b%b%b", n, s, l, v);
    endtask
    task automatic run_rx(input logic v, input logic l, input logic s, input int n, input int flen, input int base,
        input logic ovf);
        int q;
        int w;
        logic [7:0] b;
        logic [31:0] d;
        fill_mem(v, l, s, flen, n, base);
        #1;
        for (int p = 0; p < n; p++) begin
            b = 8'($urandom);
            i_serial_device_model.rx_q.push_back({!ovf && p == n - 1, b});
            q = src_idx(p, n, l, s, 1'b0);
            w = (base + (l ? q : q / 2)) % 64;
            if (l) mem[w] = {8'h00, b};
            else if (q % 2 == 1) mem[w][15:8] = b;
            else begin
                mem[w][7:0] = b;
                if (p == n - 1) msk[w] = 16'h00FF;
            end
        end
        wr(packer_pkg::OFS_CMD, 32'h2);
        for (int k = 0; k < 400; k++) begin
            @(posedge i_ref_clk);
            #1;
            if (o_rx_ready !== 1'b1) break;
        end
        check(32'(i_serial_device_model.rx_q.size()), 32'h0, "bytes left unread");
        rchk(packer_pkg::OFS_RX_COUNT, 32'(n), "receive count");
        rchk(packer_pkg::OFS_STATUS, ovf ? 32'hC : 32'h4, "receive status");
        wr(packer_pkg::OFS_STATUS, 32'hF);
        wr(packer_pkg::OFS_MEM_ADDR, 32'h0);
        for (int i = 0; i < 64; i++) begin
            rd(packer_pkg::OFS_MEM_DATA, d);
            check(d & {16'h0, msk[i]}, {16'h0, mem[i] & msk[i]}, "stored word");
        end
        $display("receive test done: len %0d ctrl %b%b%b", n, s, l, v);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #900000;
        bad_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end
    initial begin
        logic v, l, s;
        int n, fl;
        void'($urandom(69776));
        repeat (10) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rchk(packer_pkg::OFS_CTRL, 32'h0, "reset control");
        rchk(packer_pkg::OFS_FIELD_LEN, 32'h1, "reset length");
        rchk(packer_pkg::OFS_VAR_LEN, 32'h1, "reset variable length");
        rchk(packer_pkg::OFS_STATUS, 32'h0, "reset status");
        wr(8'h3C, 32'hFFFFFFFF);
        rchk(8'h3C, 32'h0, "unmapped address");
        wr(packer_pkg::OFS_FIELD_LEN, 32'h0);
        rchk(packer_pkg::OFS_FIELD_LEN, 32'h1, "length floor");
        wr(packer_pkg::OFS_FIELD_LEN, 32'hFFF);
        rchk(packer_pkg::OFS_FIELD_LEN, 32'h800, "length ceiling");
        wr(packer_pkg::OFS_VAR_LEN, 32'h900);
        rchk(packer_pkg::OFS_VAR_LEN, 32'h800, "variable length ceiling");
        wr(packer_pkg::OFS_FIELD_LEN, 32'h5);
        wr(packer_pkg::OFS_VAR_LEN, 32'h9);
        rchk(packer_pkg::OFS_VAR_LEN, 32'h5, "variable length bound");
        run_tx(1'b0, 1'b0, 1'b1, 3, 3, 10);
        run_tx(1'b0, 1'b1, 1'b1, 3, 3, 62);
        run_tx(1'b1, 1'b0, 1'b0, 1, 8, 0);
        run_rx(1'b0, 1'b0, 1'b1, 3, 3, 5, 1'b0);
        run_rx(1'b1, 1'b0, 1'b0, 4, 4, 0, 1'b1);
        for (int t = 0; t < 24; t++) begin
            v = 1'($urandom);
            l = 1'($urandom);
            s = 1'($urandom);
            n = $urandom_range(12, 1);
            fl = v ? n + $urandom_range(4, 0) : n;
            if (t % 2 == 0) run_tx(v, l, s, n, fl, $urandom_range(63, 0));
            else run_rx(v, l, s, n, fl, $urandom_range(63, 0), 1'b0);
        end
        complete_run();
    end
endmodule
